// ===== rtl/sec_pkg.sv
// constants and carrier types for the serial eeprom command engine
package sec_pkg;
	// ------------------------------------------------------------
	// array shape
	// ------------------------------------------------------------
	localparam int WIDE_WORDS = 128;               // words in 16-bit organisation
	localparam int NARROW_WORDS = 256;             // words in 8-bit organisation
	localparam int WIDE_ABITS = 7;                 // address bits, 16-bit words
	localparam int NARROW_ABITS = 8;               // address bits, 8-bit words
	localparam int WIDE_DBITS = 16;                // data bits, 16-bit words
	localparam int NARROW_DBITS = 8;               // data bits, 8-bit words
	localparam int OPC_BITS = 2;                   // opcode length
	localparam int CNT_W = 5;                      // width of bit counters
	// ------------------------------------------------------------
	// opcodes and extended codes
	// ------------------------------------------------------------
	localparam logic [1:0] OPC_EXT = 2'h0;         // extended group
	localparam logic [1:0] OPC_WRITE = 2'h1;       // word write
	localparam logic [1:0] OPC_READ = 2'h2;        // read
	localparam logic [1:0] OPC_ERASE = 2'h3;       // word erase
	localparam logic [1:0] EXT_LOCK = 2'h0;        // program_lock
	localparam logic [1:0] EXT_FILL = 2'h1;        // bulk_fill
	localparam logic [1:0] EXT_BULK_ERASE = 2'h2;  // bulk_erase
	localparam logic [1:0] EXT_UNLOCK = 2'h3;      // program_unlock
	localparam logic [15:0] ERASED_WORD = 16'hFFFF; // value of an erased cell
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 25;                   // mclk rate
	localparam int PROG_MS = 10;                   // longest programming cycle
	localparam int PROG_CYCLES = PROG_MS * 1000 * CLK_MHZ; // exact product, no rounding
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEC_IDLE, SEC_OPC, SEC_ADDR, SEC_DATA, SEC_READ, SEC_ARMED, SEC_DONE
	} sec_state_t;
	typedef enum logic [2:0] {
		SEC_JOB_NONE, SEC_JOB_ERASE, SEC_JOB_WRITE, SEC_JOB_BULK_ERASE, SEC_JOB_FILL
	} sec_job_t;
	typedef struct packed {
		logic chip_select;   // host select, high active
		logic shift_clock;   // host shift clock
		logic serial_in;     // host data to device
	} sec_link_in_t;
	typedef struct packed {
		logic dout;          // level on serial output
		logic dout_oe_n;     // low while the device drives
	} sec_link_out_t;
endpackage : sec_pkg

// ===== rtl/sec_engine.sv
// serial eeprom command engine: decoder, read shifter, self-timed programmer
//
// What this block does
// - 2048 bits, 128x16 or 256x8 words
// - instruction 10 bits, or 11 in 8-bit
// - sample serial input on shift clock rise
// - output tristated except read data or status
// - status low while busy, high when ready
// - one on input then tristate at fall
// - start bit, opcode, address, optional data field
// - read: dummy zero then word data out
// - read data changes on shift clock rise
// - power-up state is programming locked
// - unlock holds until lock instruction arrives
// - reads work whether locked or not
// - word erase starts at select falling
// - word write erases then stores at deselect
// - write needs no prior erase
// - bulk erase starts at select falling
// - bulk fill starts at select falling
// - programming finishes without shift clocks
// - opcodes 10 read, 11 erase, 01 write
// - opcode 00 extended by top address bits
// - select high gives 16-bit words
// - programming completes within 10 ms
`timescale 1ns/1ps
`default_nettype none
module sec_engine #(
	parameter int PROG_TICKS = sec_pkg::PROG_CYCLES  // programming time in mclk cycles
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire sec_pkg::sec_link_in_t link_in,
	input wire logic word_width_select,
	output sec_pkg::sec_link_out_t link_out,
	output logic busy
);
	import sec_pkg::*;

	// ------------------------------------------------------------
	// input synchronisers and edge detection
	// ------------------------------------------------------------
	sec_link_in_t meta_ff, sync_ff, prev_ff;  // two flops, then history
	logic org_meta_ff, org_ff;                 // organisation pin sync
	logic sk_rise, sk_fall, cs_fall;           // edge events
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
			org_meta_ff <= 1'b1;
			org_ff <= 1'b1;
		end else begin
			meta_ff <= link_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			org_meta_ff <= word_width_select;
			org_ff <= org_meta_ff;
		end
	end
	assign sk_rise = sync_ff.shift_clock & ~prev_ff.shift_clock;
	assign sk_fall = ~sync_ff.shift_clock & prev_ff.shift_clock;
	assign cs_fall = ~sync_ff.chip_select & prev_ff.chip_select;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// address length for the current organisation
	function automatic logic [CNT_W-1:0] addr_len(input logic wide);
		addr_len = wide ? CNT_W'(WIDE_ABITS) : CNT_W'(NARROW_ABITS);
	endfunction : addr_len
	// data length for the current organisation
	function automatic logic [CNT_W-1:0] data_len(input logic wide);
		data_len = wide ? CNT_W'(WIDE_DBITS) : CNT_W'(NARROW_DBITS);
	endfunction : data_len

	// ------------------------------------------------------------
	// storage: 2048 bits as 256 bytes; a wide word is a byte pair
	// ------------------------------------------------------------
	logic [7:0] mem_ff [NARROW_WORDS];
	logic [7:0] nxt_mem [NARROW_WORDS];

	// ------------------------------------------------------------
	// command state
	// ------------------------------------------------------------
	sec_state_t state_ff, nxt_state;
	sec_job_t job_ff, nxt_job;          // programming job armed or running
	logic [1:0] opc_ff, nxt_opc;
	logic [7:0] addr_ff, nxt_addr;
	logic [15:0] data_ff, nxt_data;     // write data or read shifter
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic unlocked_ff, nxt_unlocked;
	logic wide_ff, nxt_wide;            // organisation latched per instruction
	logic [23:0] timer_ff, nxt_timer;
	logic busy_ff, nxt_busy;
	logic status_ff, nxt_status;        // status reporting enabled
	logic dout_ff, nxt_dout;
	logic oe_n_ff, nxt_oe_n;

	always_comb begin
		nxt_state = state_ff;
		nxt_job = job_ff;
		nxt_opc = opc_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_cnt = cnt_ff;
		nxt_unlocked = unlocked_ff;
		nxt_wide = wide_ff;
		nxt_timer = timer_ff;
		nxt_busy = busy_ff;
		nxt_status = status_ff;
		nxt_dout = dout_ff;
		nxt_oe_n = oe_n_ff;
		nxt_mem = mem_ff;
		// self-timed programming, independent of the shift clock
		if (busy_ff) begin
			if (timer_ff == 24'(PROG_TICKS - 1)) begin
				nxt_busy = 1'b0;
				nxt_timer = '0;
				case (job_ff)
					SEC_JOB_ERASE: begin
						if (wide_ff) begin
							nxt_mem[{addr_ff[6:0], 1'b0}] = ERASED_WORD[7:0];
							nxt_mem[{addr_ff[6:0], 1'b1}] = ERASED_WORD[7:0];
						end else begin
							nxt_mem[addr_ff] = ERASED_WORD[7:0];
						end
					end
					SEC_JOB_WRITE: begin  // auto-erase: word replaced whole
						if (wide_ff) begin
							nxt_mem[{addr_ff[6:0], 1'b0}] = data_ff[15:8];
							nxt_mem[{addr_ff[6:0], 1'b1}] = data_ff[7:0];
						end else begin
							nxt_mem[addr_ff] = data_ff[7:0];
						end
					end
					SEC_JOB_BULK_ERASE: begin
						for (int i = 0; i < NARROW_WORDS; i++) begin
							nxt_mem[i] = ERASED_WORD[7:0];
						end
					end
					SEC_JOB_FILL: begin  // cells only pulled low, hence prior erase
						for (int i = 0; i < NARROW_WORDS; i++) begin
							nxt_mem[i] = mem_ff[i] & (wide_ff ? (i[0] ? data_ff[7:0] : data_ff[15:8]) : data_ff[7:0]);
						end
					end
					default: begin
					end
				endcase
				nxt_job = SEC_JOB_NONE;
			end else begin
				nxt_timer = timer_ff + 24'h000001;
			end
		end
		// deselect ends every frame and releases the output
		if (!sync_ff.chip_select) begin
			nxt_oe_n = 1'b1;
			nxt_status = 1'b0;
			nxt_state = SEC_IDLE;
			// a refused (locked) instruction arms no job, so deselect starts nothing
			if (cs_fall && state_ff == SEC_ARMED && !busy_ff && job_ff != SEC_JOB_NONE) begin
				nxt_busy = 1'b1;
				nxt_timer = '0;
				nxt_status = 1'b1;
			end else if (state_ff == SEC_ARMED) begin
				nxt_job = SEC_JOB_NONE;
			end
			if (busy_ff || job_ff != SEC_JOB_NONE) begin
				nxt_status = (cs_fall && state_ff == SEC_ARMED) || status_ff;
			end
		end else begin
			// status reporting on the output while selected
			if (status_ff && state_ff == SEC_IDLE) begin
				nxt_oe_n = 1'b0;
				nxt_dout = ~busy_ff;
			end
			if (sk_fall && status_ff && state_ff == SEC_OPC && cnt_ff == '0) begin
				nxt_status = 1'b0;
				nxt_oe_n = 1'b1;
			end
			if (sk_rise) begin
				case (state_ff)
					SEC_IDLE: begin
						if (sync_ff.serial_in) begin
							nxt_state = SEC_OPC;
							nxt_cnt = '0;
						end
					end
					SEC_OPC: begin
						nxt_opc = {opc_ff[0], sync_ff.serial_in};
						nxt_cnt = cnt_ff + CNT_W'(1);
						if (cnt_ff == CNT_W'(OPC_BITS - 1)) begin
							nxt_cnt = '0;
							if (busy_ff) begin
								// a running job owns address, data and width: drop the rest of this frame
								nxt_state = SEC_DONE;
							end else begin
								nxt_state = SEC_ADDR;
								nxt_wide = org_ff;
							end
						end
					end
					SEC_ADDR: begin
						nxt_addr = {addr_ff[6:0], sync_ff.serial_in};
						nxt_cnt = cnt_ff + CNT_W'(1);
						if (cnt_ff == addr_len(wide_ff) - CNT_W'(1)) begin
							nxt_cnt = '0;
							nxt_state = SEC_IDLE;
							case (opc_ff)
								OPC_READ: begin  // no lock check
									nxt_state = SEC_READ;
									nxt_oe_n = 1'b0;  // dummy zero
									nxt_dout = 1'b0;
									nxt_status = 1'b0;
								end
								OPC_ERASE: begin
									nxt_state = SEC_ARMED;
									nxt_job = unlocked_ff ? SEC_JOB_ERASE : SEC_JOB_NONE;
								end
								OPC_WRITE: nxt_state = SEC_DATA;
								default: begin
									case (wide_ff ? addr_ff[5:4] : addr_ff[6:5])
										EXT_UNLOCK: nxt_unlocked = 1'b1;
										EXT_LOCK: nxt_unlocked = 1'b0;
										EXT_BULK_ERASE: begin
											nxt_state = SEC_ARMED;
											nxt_job = unlocked_ff ? SEC_JOB_BULK_ERASE : SEC_JOB_NONE;
										end
										default: nxt_state = SEC_DATA;
									endcase
								end
							endcase
						end
					end
					SEC_DATA: begin
						nxt_data = {data_ff[14:0], sync_ff.serial_in};
						nxt_cnt = cnt_ff + CNT_W'(1);
						if (cnt_ff == data_len(wide_ff) - CNT_W'(1)) begin
							nxt_state = SEC_ARMED;
							if (!unlocked_ff) begin
								nxt_job = SEC_JOB_NONE;
							end else if (opc_ff == OPC_WRITE) begin
								nxt_job = SEC_JOB_WRITE;
							end else begin
								nxt_job = SEC_JOB_FILL;
							end
						end
					end
					SEC_READ: begin  // each bit moves on a rise
						nxt_cnt = cnt_ff + CNT_W'(1);
						if (cnt_ff == '0) begin
							// first rise: fetch the word and show its top bit
							nxt_data = wide_ff ? {mem_ff[{addr_ff[6:0], 1'b0}], mem_ff[{addr_ff[6:0], 1'b1}]}
								: {mem_ff[addr_ff], 8'h00};
							nxt_dout = wide_ff ? mem_ff[{addr_ff[6:0], 1'b0}][7] : mem_ff[addr_ff][7];
						end else if (cnt_ff == data_len(wide_ff)) begin
							// rise after the last bit releases the line; level held, never indexed past the word
							nxt_oe_n = 1'b1;
							nxt_state = SEC_DONE;
						end else begin
							nxt_dout = data_ff[WIDE_DBITS - 1 - 32'(cnt_ff)];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_ff <= SEC_IDLE;
			job_ff <= SEC_JOB_NONE;
			opc_ff <= '0;
			addr_ff <= '0;
			data_ff <= '0;
			cnt_ff <= '0;
			unlocked_ff <= 1'b0;
			wide_ff <= 1'b1;
			timer_ff <= '0;
			busy_ff <= 1'b0;
			status_ff <= 1'b0;
			dout_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			for (int i = 0; i < NARROW_WORDS; i++) begin
				mem_ff[i] <= ERASED_WORD[7:0];
			end
		end else begin
			state_ff <= nxt_state;
			job_ff <= nxt_job;
			opc_ff <= nxt_opc;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			cnt_ff <= nxt_cnt;
			unlocked_ff <= nxt_unlocked;
			wide_ff <= nxt_wide;
			timer_ff <= nxt_timer;
			busy_ff <= nxt_busy;
			status_ff <= nxt_status;
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
			mem_ff <= nxt_mem;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link_out.dout = dout_ff;
	assign link_out.dout_oe_n = oe_n_ff;
	assign busy = busy_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_reset_locked: assert property (@(posedge mclk) $fell(sys_rst) |-> !unlocked_ff)
		else $error("engine not locked after reset");
	a_busy_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
		busy_ff |-> timer_ff < 24'(PROG_TICKS))
		else $error("programming overran");
	a_deselect_release: assert property (@(posedge mclk) disable iff (sys_rst)
		!sync_ff.chip_select |=> oe_n_ff)
		else $error("output driven while deselected");
	a_status_level: assert property (@(posedge mclk) disable iff (sys_rst)
		(!oe_n_ff && state_ff == SEC_IDLE) |-> dout_ff == ~$past(busy_ff))
		else $error("status level wrong");
	// a cycle only ever starts with a real job, and only when unlocked
	a_locked_no_job: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(busy_ff) |-> unlocked_ff && job_ff != SEC_JOB_NONE)
		else $error("programming while locked");
	a_start_on_cs: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(busy_ff) |-> $past(cs_fall))
		else $error("programming started without deselect");
	a_read_dummy: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(state_ff == SEC_READ) |-> !dout_ff && !oe_n_ff)
		else $error("read dummy bit missing");
	a_read_on_rise: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_ff == SEC_READ && $changed(dout_ff)) |-> $past(sk_rise))
		else $error("read bit moved off a rise");
endmodule : sec_engine
`default_nettype wire

// ===== sim/sec_host.sv
// host model that drives select, shift clock and serial input of the link
`timescale 1ns/1ps
`default_nettype none
module sec_host (
	input wire logic mclk,
	output var sec_pkg::sec_link_in_t link_in,
	input wire sec_pkg::sec_link_out_t link_out
);
	import sec_pkg::*;
	// ------------------------------------------------------------
	// link idles deselected, shift clock standing low
	// ------------------------------------------------------------
	initial link_in = '0;
	// one bit: 4 mclk low, sample output, rise, 4 mclk high, fall (320 ns period)
	task automatic clk_bit(input logic b, output logic [1:0] s);
		link_in.serial_in <= b;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		// a released output shows the inverse of its last level, so stale bits never pass
		s = {link_out.dout_oe_n, link_out.dout_oe_n ? ~link_out.dout : link_out.dout};
		@(posedge mclk);
		link_in.shift_clock <= 1'b1;
		repeat (4) @(posedge mclk);
		link_in.shift_clock <= 1'b0;
	endtask : clk_bit
	// select or deselect, then settle; 8 mclk covers the minimum low time
	task automatic sel(input logic on);
		link_in.chip_select <= on;
		if (!on) link_in.serial_in <= ~link_in.serial_in; // released line shows no stale level
		repeat (8) @(posedge mclk);
	endtask : sel
	// framed transfer: n bits msb first, then the lead bit and nrd read bits
	task automatic frame(input logic [39:0] v, input int n, input int nrd, output logic [1:0] lead,
		output logic [15:0] rd);
		logic [1:0] s;
		rd = '0;
		lead = 2'h3;
		sel(1'b1);
		for (int i = n - 1; i >= 0; i--) clk_bit(v[i], s);
		for (int k = 0; nrd > 0 && k <= nrd; k++) begin
			clk_bit(1'b0, s);
			if (k == 0) lead = s;
			else rd = {rd[14:0], s[0]};
		end
		sel(1'b0);
	endtask : frame
endmodule : sec_host
`default_nettype wire

// ===== sim/serial_eeprom_command_engine_tb.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_engine_tb;
	import sec_pkg::*;
	localparam int TICKS = 50; // shortened programming time
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic word_width_select = 1'b1;
	sec_link_in_t link_in;
	sec_link_out_t link_out;
	logic busy;
	int num_errors = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h59;
	logic [7:0] mem [256]; // expected contents, byte view
	logic [1:0] lead;
	logic [15:0] rd;
	always #20 mclk = ~mclk;
	sec_engine #(.PROG_TICKS(TICKS)) sec_engine_i (.mclk(mclk), .sys_rst(sys_rst), .link_in(link_in),
		.word_width_select(word_width_select), .link_out(link_out), .busy(busy));
	sec_host sec_host_i (.mclk(mclk), .link_in(link_in), .link_out(link_out));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [15:0] exp_rd(input logic [7:0] a);
		return word_width_select ? {mem[{a[6:0], 1'b0}], mem[{a[6:0], 1'b1}]} : {8'h00, mem[a]};
	endfunction : exp_rd
	function automatic logic [7:0] ext_addr(input logic [1:0] e, input logic [7:0] junk);
		return word_width_select ? {1'b0, e, junk[4:0]} : {e, junk[5:0]};
	endfunction : ext_addr
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// build and send one instruction, pad leading zeros before the start bit
	task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d, input bit rdo, input int pad);
		logic [39:0] v;
		int ab;
		int db;
		bit hd;
		ab = word_width_select ? 7 : 8;
		db = word_width_select ? 16 : 8;
		hd = op == OPC_WRITE || (op == OPC_EXT && ext_addr(2'h0, 8'h0) == 8'h0 &&
			(word_width_select ? a[6:5] : a[7:6]) == EXT_FILL);
		v = 40'h1;
		v = (v << 2) | 40'(op);
		v = (v << ab) | 40'(word_width_select ? {1'b0, a[6:0]} : a);
		if (hd) v = (v << db) | 40'(word_width_select ? d : {8'h00, d[7:0]});
		sec_host_i.frame(v, 3 + ab + (hd ? db : 0) + pad, rdo ? db : 0, lead, rd);
	endtask : cmd
	task automatic idle_chk();
		@(negedge mclk);
		check("refused busy", 16'(busy), 16'h0);
		@(posedge mclk);
	endtask : idle_chk
	task automatic rd_chk(input logic [7:0] a, input int pad);
		cmd(OPC_READ, a, 16'h0, 1, pad);
		check("lead bit", 16'(lead), 16'h0);
		check("read data", rd, exp_rd(a));
		@(negedge mclk);
		check("idle oe", 16'(link_out.dout_oe_n), 16'h1);
		@(posedge mclk);
	endtask : rd_chk
	// select after a started cycle and follow status until ready, then release it
	task automatic poll();
		logic [1:0] s;
		int k;
		sec_host_i.sel(1'b1);
		@(negedge mclk);
		check("busy", 16'(busy), 16'h1);
		check("status busy", 16'({link_out.dout_oe_n, link_out.dout}), 16'h0);
		k = 0;
		while (link_out.dout !== 1'b1 && k < TICKS) begin
			@(negedge mclk);
			k++;
		end
		if (k == TICKS) begin
			num_errors++;
			complete_run();
		end
		check("status ready", 16'({link_out.dout_oe_n, link_out.dout, busy}), 16'h2);
		@(posedge mclk);
		sec_host_i.clk_bit(1'b1, s);
		repeat (6) @(negedge mclk);
		check("status release", 16'(link_out.dout_oe_n), 16'h1);
		@(posedge mclk);
		sec_host_i.sel(1'b0);
	endtask : poll
	// programming operation with model update
	task automatic prog(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
		logic [1:0] e;
		cmd(op, a, d, 0, 0);
		poll();
		e = word_width_select ? a[6:5] : a[7:6];
		for (int i = 0; i < 256; i++) begin
			if (op == OPC_EXT && e == EXT_BULK_ERASE) mem[i] = 8'hFF;
			if (op == OPC_EXT && e == EXT_FILL) mem[i] = mem[i] & ((word_width_select && !i[0]) ? d[15:8] : d[7:0]);
		end
		if (op != OPC_EXT && word_width_select) begin
			mem[{a[6:0], 1'b0}] = op == OPC_ERASE ? 8'hFF : d[15:8];
			mem[{a[6:0], 1'b1}] = op == OPC_ERASE ? 8'hFF : d[7:0];
		end else if (op != OPC_EXT) mem[a] = op == OPC_ERASE ? 8'hFF : d[7:0];
	endtask : prog
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [7:0] a;
		logic [15:0] d;
		for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		r = rnd();
		a = {1'b0, r[6:0]};
		d = r[31:16];
		cmd(OPC_WRITE, a, d, 0, 0);
		idle_chk();
		rd_chk(a, 2);
		$display("test locked start done");
		cmd(OPC_EXT, ext_addr(EXT_UNLOCK, r[7:0]), 16'h0, 0, 0);
		for (int t = 0; t < 4; t++) begin
			r = rnd();
			a = t == 0 ? 8'h00 : (t == 1 ? 8'h7F : {1'b0, r[6:0]});
			d = r[31:16];
			prog(OPC_WRITE, a, d);
			if (t == 3) prog(OPC_WRITE, a, ~d);
			rd_chk(a, 0);
		end
		prog(OPC_ERASE, a, 16'h0);
		rd_chk(a, 0);
		$display("test word program done");
		cmd(OPC_EXT, ext_addr(EXT_LOCK, r[15:8]), 16'h0, 0, 0);
		for (int j = 0; j < 4; j++) begin
			cmd(j < 2 ? (j == 0 ? OPC_WRITE : OPC_ERASE) : OPC_EXT,
				j < 2 ? a : ext_addr(j == 2 ? EXT_BULK_ERASE : EXT_FILL, r[7:0]), r[15:0], 0, 0);
			idle_chk();
		end
		rd_chk(a, 0);
		rd_chk(8'h00, 0);
		$display("test lock done");
		cmd(OPC_EXT, ext_addr(EXT_UNLOCK, r[23:16]), 16'h0, 0, 0);
		prog(OPC_EXT, ext_addr(EXT_BULK_ERASE, r[7:0]), 16'h0);
		rd_chk(8'h7F, 0);
		r = rnd();
		prog(OPC_EXT, ext_addr(EXT_FILL, r[7:0]), r[31:16]);
		rd_chk({1'b0, r[6:0]}, 0);
		rd_chk(8'h00, 0);
		$display("test bulk done");
		word_width_select <= 1'b0;
		repeat (4) @(posedge mclk);
		r = rnd();
		prog(OPC_EXT, ext_addr(EXT_BULK_ERASE, r[23:16]), 16'h0);
		prog(OPC_EXT, ext_addr(EXT_FILL, r[31:24]), r[15:0]);
		rd_chk(r[23:16], 0);
		prog(OPC_WRITE, r[7:0], {8'h00, r[15:8]});
		rd_chk(r[7:0], 0);
		rd_chk(r[7:0] ^ 8'h01, 0);
		word_width_select <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_chk({1'b0, r[7:1]}, 0);
		$display("test narrow words done");
		complete_run();
	end
endmodule : serial_eeprom_command_engine_tb
`default_nettype wire
